// ===== nvsc_access.sv
// Purpose: one chip-select framed access on the asynchronous bus
// Assumes: caller holds address and data stable while busy
// Notes:   read data captured at the end of the strobe window
`timescale 1ns/1ps
`include "nvsc_cfg.svh"
module nvsc_access (
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire logic                    start,
  input  wire logic                    is_write,
  input  wire logic                    drive_oe,
  input  wire logic [15:0]             dq_in_sync,
  output logic                         chip_sel_n,
  output logic                         write_n,
  output logic                         out_en_n,
  output logic                         dq_oe,
  output logic                         done,
  output logic [15:0]                  rd_data
);
  typedef struct packed {
    logic                  act;
    logic                  wr;
    logic                  oe;
    logic [`NVSC_CNT_W-1:0] cnt;
    logic                  done;
    logic [15:0]           rd;
  } nvsc_acc_t;
  nvsc_acc_t st_r, st_nxt;

  // ---------------------------------------------------------------
  // access timer
  // ---------------------------------------------------------------
  // count a fixed window; two extra cycles cover the input synchroniser
  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    if (!st_r.act && start) begin
      st_nxt.act = 1'b1;
      st_nxt.wr  = is_write;
      st_nxt.oe  = drive_oe;
      st_nxt.cnt = `NVSC_CNT_W'(`NVSC_ACC_CYC + 2);
    end else if (st_r.act) begin
      if (st_r.cnt == '0) begin
        st_nxt.act  = 1'b0;
        st_nxt.done = 1'b1;
        st_nxt.rd   = dq_in_sync;
      end else begin
        st_nxt.cnt = st_r.cnt - `NVSC_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign chip_sel_n = ~st_r.act;                       // R10
  assign write_n    = ~(st_r.act & st_r.wr);            // R3
  assign out_en_n   = ~(st_r.act & ~st_r.wr & st_r.oe); // R9
  assign dq_oe      = st_r.act & st_r.wr;
  assign done       = st_r.done;
  assign rd_data    = st_r.rd;
endmodule : nvsc_access

// ===== nvsc_cfg.svh
// Purpose: constants for the host-side soft sequence controller
// Assumes: 50 MHz clk, one access slot per command word
// Notes:   offsets and counts used by nvsc_host and nvsc_access
// Functional notes
// [R1] device matches only address bits 14..2 of sequence addresses
// [R2] host issues the six sequence addresses in listed order, back to back
// [R3] write strobe stays high during all six sequence accesses
// [R4] prefix reads are 0x4E38, 0xB1C7, 0x83E0, 0x7C1F, 0x703F
// [R5] sixth read 0x8B45 turns power-fail save off
// [R6] sixth read 0x4B46 turns power-fail save back on
// [R7] sixth read 0x8FC0 starts a nonvolatile store, data pins high-z
// [R8] sixth read 0x4C63 starts a recall, data pins high-z
// [R9] data pins driven per output enable and byte selects
// [R10] sequences are chip-select framed read cycles
// [R11] host follows a save-setting change with a manual store; nvsc_host only flags it on save_changed
// [R12] stored save setting starts in the enabled state
// [R13] device ignores stores and writes below supply threshold
// [R14] write held at power up or end of cycle is blocked
// [R15] nothing else inserted; no access during processing interval
// [R16] device holds busy/store low through every store
// [R17] device matcher restarts on mismatch
`ifndef NVSC_CFG_SVH
`define NVSC_CFG_SVH
`define NVSC_ADDR_W       18
`define NVSC_SEQ_0        16'h4e38
`define NVSC_SEQ_1        16'hb1c7
`define NVSC_SEQ_2        16'h83e0
`define NVSC_SEQ_3        16'h7c1f
`define NVSC_SEQ_4        16'h703f
`define NVSC_SEQ_OFF      16'h8b45
`define NVSC_SEQ_ON       16'h4b46
`define NVSC_SEQ_STORE    16'h8fc0
`define NVSC_SEQ_RECALL   16'h4c63
`define NVSC_CLK_MHZ      50
`define NVSC_ACC_NS       60
`define NVSC_ACC_CYC      ((`NVSC_ACC_NS * `NVSC_CLK_MHZ + 999) / 1000)
`define NVSC_TSS_NS       100000
`define NVSC_TSS_CYC      ((`NVSC_TSS_NS * `NVSC_CLK_MHZ + 999) / 1000)
`define NVSC_CNT_W        16
`endif

// ===== nvsc_dev_model.sv
// Purpose: behavioural memory device with soft sequence decoder
// Assumes: 256 words are enough, indexed by address bits 7..0
// Notes:   settles 1 ns after select falls to dodge edge races
`timescale 1ns/1ps
`include "nvsc_cfg.svh"
module nvsc_dev_model #(
  parameter int STORE_NS = 2000
) (
  input wire logic [`NVSC_ADDR_W-1:0] mem_addr,
  input wire logic                    chip_sel_n,
  input wire logic                    write_n,
  input wire logic                    out_en_n,
  input wire logic                    upper_byte_sel_n,
  input wire logic                    lower_byte_sel_n,
  input wire logic [15:0]             dq_out,
  input wire logic                    dq_oe,
  input wire logic                    supply_low,
  output logic [15:0]                 dq_in,
  output logic                        busy_low,
  output logic                        pfs_en,
  output logic                        pfs_nv
);
  logic [15:0] mem [0:255];
  logic [15:0] nv  [0:255];
  logic [15:0] last_q = 16'h0000;
  logic [2:0]  step = 3'h0;
  logic [1:0]  pend = 2'h0;
  logic        hiz6 = 1'b0;
  logic [12:0] seq [0:4] = '{13'(`NVSC_SEQ_0 >> 2), 13'(`NVSC_SEQ_1 >> 2),
    13'(`NVSC_SEQ_2 >> 2), 13'(`NVSC_SEQ_3 >> 2), 13'(`NVSC_SEQ_4 >> 2)};
  initial busy_low = 1'b0;
  initial pfs_en = 1'b1;
  initial pfs_nv = 1'b1;
  function automatic logic [12:0] k(input logic [15:0] a);
    return a[14:2];
  endfunction : k
  // undriven pins show the inverse of the last value, never a stale copy
  always @* begin
    dq_in = ~last_q;
    if (dq_oe) dq_in = dq_out;
    else if (!chip_sel_n && write_n && !out_en_n && !hiz6 && !busy_low) begin
      if (!upper_byte_sel_n) dq_in[15:8] = mem[mem_addr[7:0]][15:8];
      if (!lower_byte_sel_n) dq_in[7:0] = mem[mem_addr[7:0]][7:0];
    end
  end
  // sequence matcher and writes
  always @(negedge chip_sel_n) begin
    #1;
    hiz6 = 1'b0;
    pend = 2'h0;
    if (!write_n) begin
      step = 3'h0;
      // writes dropped while supply is low or a store holds busy
      if (!supply_low && !busy_low) begin
        if (!lower_byte_sel_n) mem[mem_addr[7:0]][7:0] = dq_out[7:0];
        if (!upper_byte_sel_n) mem[mem_addr[7:0]][15:8] = dq_out[15:8];
      end
    end else if (step == 3'h5) begin
      step = 3'h0;
      case (k(mem_addr[15:0]))
        k(`NVSC_SEQ_OFF):    pfs_en = 1'b0;
        k(`NVSC_SEQ_ON):     pfs_en = 1'b1;
        k(`NVSC_SEQ_STORE):  pend = 2'h1;
        k(`NVSC_SEQ_RECALL): pend = 2'h2;
        default:             step = {2'h0, k(mem_addr[15:0]) == seq[0]};
      endcase
      hiz6 = pend != 2'h0;
    end else if (k(mem_addr[15:0]) == seq[step]) step = step + 3'h1;
    else step = {2'h0, k(mem_addr[15:0]) == seq[0]};
  end
  // store or recall starts once the sixth access ends
  always @(posedge chip_sel_n) begin
    last_q = dq_in;
    if (pend == 2'h2) begin
      mem = nv;
      pfs_en = pfs_nv;
    end
    if (pend == 2'h1 && !supply_low) begin
      busy_low = 1'b1;
      #(STORE_NS);
      nv = mem;
      pfs_nv = pfs_en;
      busy_low = 1'b0;
    end
  end
endmodule : nvsc_dev_model

// ===== nvsc_host.sv
// Purpose: host controller issuing reads, writes and soft sequences
// Assumes: device busy/store pin is open drain with pull-up
// Notes:   one command at a time; ready low while working
`timescale 1ns/1ps
`include "nvsc_cfg.svh"
module nvsc_host #(
  parameter int unsigned TSS_CYC = `NVSC_TSS_CYC
) (
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire logic                    cmd_valid,
  input  wire nvsc_pkg::nvsc_cmd_t     cmd_code,
  input  wire logic [`NVSC_ADDR_W-1:0] cmd_addr,
  input  wire logic [15:0]             cmd_wdata,
  input  wire logic [1:0]              cmd_bytes,
  output logic                         cmd_ready,
  output logic                         rsp_valid,
  output logic [15:0]                  rsp_rdata,
  output logic                         save_changed,
  output logic [`NVSC_ADDR_W-1:0]      mem_addr,
  output logic                         chip_sel_n,
  output logic                         write_n,
  output logic                         out_en_n,
  output logic                         upper_byte_sel_n,
  output logic                         lower_byte_sel_n,
  output logic [15:0]                  dq_out,
  output logic                         dq_oe,
  input  wire logic [15:0]             dq_in,
  input  wire logic                    store_busy_n_in,
  output logic                         store_busy_n_out,
  output logic                         store_busy_n_oe
);
  typedef struct packed {
    nvsc_pkg::nvsc_state_t  fsm;
    nvsc_pkg::nvsc_cmd_t    cmd;
    logic [2:0]             step;
    logic [`NVSC_ADDR_W-1:0] addr;
    logic [15:0]            wdata;
    logic [1:0]             bytes;
    logic [`NVSC_CNT_W-1:0] cnt;
    logic                   rsp;
    logic [15:0]            rdata;
    logic                   chg;
    logic [15:0]            dq_s1;
    logic [15:0]            dq_s2;
    logic [1:0]             busy_s;
  } nvsc_host_t;
  nvsc_host_t st_r, st_nxt;

  // busy stages reset high: the pin idles high behind its pull-up, and a
  // low reset value would hold cmd_ready down for two cycles after reset
  localparam nvsc_host_t HOST_RST = '{
    fsm:    nvsc_pkg::NVSC_IDLE,
    cmd:    nvsc_pkg::NVSC_CMD_READ,
    step:   3'h0,
    addr:   {`NVSC_ADDR_W{1'b0}},
    wdata:  16'h0000,
    bytes:  2'h0,
    cnt:    {`NVSC_CNT_W{1'b0}},
    rsp:    1'b0,
    rdata:  16'h0000,
    chg:    1'b0,
    dq_s1:  16'h0000,
    dq_s2:  16'h0000,
    busy_s: 2'h3
  };

  logic        acc_start;
  logic        acc_done;
  logic [15:0] acc_rd;
  logic        seq_cmd;

  // ---------------------------------------------------------------
  // sequence address table
  // ---------------------------------------------------------------
  // upper bits zero; device only looks at bits 14..2 anyway
  function automatic logic [`NVSC_ADDR_W-1:0] seq_addr(
    input logic [2:0]          stp,
    input nvsc_pkg::nvsc_cmd_t c
  );
    logic [15:0] a;
    a = `NVSC_SEQ_0;
    case (stp)
      3'h0: a = `NVSC_SEQ_0; // R4
      3'h1: a = `NVSC_SEQ_1;
      3'h2: a = `NVSC_SEQ_2;
      3'h3: a = `NVSC_SEQ_3;
      3'h4: a = `NVSC_SEQ_4;
      default: begin
        case (c)
          nvsc_pkg::NVSC_CMD_PFS_OFF: a = `NVSC_SEQ_OFF;    // R5
          nvsc_pkg::NVSC_CMD_PFS_ON:  a = `NVSC_SEQ_ON;     // R6
          nvsc_pkg::NVSC_CMD_STORE:   a = `NVSC_SEQ_STORE;  // R7
          default:                    a = `NVSC_SEQ_RECALL; // R8
        endcase
      end
    endcase
    seq_addr = {{(`NVSC_ADDR_W-16){1'b0}}, a}; // R1
  endfunction : seq_addr

  assign seq_cmd = (st_r.cmd != nvsc_pkg::NVSC_CMD_READ) &&
                   (st_r.cmd != nvsc_pkg::NVSC_CMD_WRITE);

  // ---------------------------------------------------------------
  // command state machine
  // ---------------------------------------------------------------
  // no foreign access between sequence steps: it would abort the sequence
  always_comb begin
    st_nxt        = st_r;
    st_nxt.rsp    = 1'b0;
    acc_start     = 1'b0;
    // pin synchronisers; the first stage feeds only the second
    st_nxt.dq_s1  = dq_in;
    st_nxt.dq_s2  = st_r.dq_s1;
    st_nxt.busy_s = {st_r.busy_s[0], store_busy_n_in};
    case (st_r.fsm)
      // take a command only while the device is not busy
      nvsc_pkg::NVSC_IDLE: begin
        if (cmd_valid && st_r.busy_s[1]) begin
          st_nxt.cmd   = cmd_code;
          st_nxt.wdata = cmd_wdata;
          st_nxt.bytes = cmd_bytes;
          st_nxt.step  = 3'h0;
          st_nxt.fsm   = nvsc_pkg::NVSC_ACC;
          if ((cmd_code == nvsc_pkg::NVSC_CMD_READ) ||
              (cmd_code == nvsc_pkg::NVSC_CMD_WRITE)) begin
            st_nxt.addr = cmd_addr;
          end else begin
            st_nxt.addr = seq_addr(3'h0, cmd_code); // R2
          end
        end
      end
      // one-cycle pulse starts the access engine
      nvsc_pkg::NVSC_ACC: begin
        acc_start  = 1'b1;
        st_nxt.fsm = nvsc_pkg::NVSC_WAIT;
      end
      // the last access of a sequence hands over to the processing wait
      nvsc_pkg::NVSC_WAIT: begin
        if (acc_done) begin
          st_nxt.rdata = acc_rd;
          if (seq_cmd && st_r.step != 3'h5) begin
            st_nxt.step = st_r.step + 3'h1;
            st_nxt.addr = seq_addr(st_r.step + 3'h1, st_r.cmd); // R2
            st_nxt.fsm  = nvsc_pkg::NVSC_GAP;
          end else if (seq_cmd) begin
            // hold off for processing time, then for any busy
            st_nxt.cnt = `NVSC_CNT_W'(TSS_CYC);  // R15
            st_nxt.chg = (st_r.cmd == nvsc_pkg::NVSC_CMD_PFS_OFF) ||
                         (st_r.cmd == nvsc_pkg::NVSC_CMD_PFS_ON) ||
                         (st_r.chg && st_r.cmd != nvsc_pkg::NVSC_CMD_STORE); // R11
            st_nxt.fsm = nvsc_pkg::NVSC_BUSY;
          end else begin
            st_nxt.rsp = 1'b1;
            st_nxt.fsm = nvsc_pkg::NVSC_IDLE;
          end
        end
      end
      nvsc_pkg::NVSC_GAP: begin
        st_nxt.fsm = nvsc_pkg::NVSC_ACC; // one extra idle cycle; chip select is already high from the done cycle
      end
      // bus stays quiet until processing time is over and busy is high again
      nvsc_pkg::NVSC_BUSY: begin
        if (st_r.cnt != '0) begin
          st_nxt.cnt = st_r.cnt - `NVSC_CNT_W'(1);
        end else if (st_r.busy_s[1]) begin
          st_nxt.rsp = 1'b1;               // R16
          st_nxt.fsm = nvsc_pkg::NVSC_IDLE;
        end
      end
      default: begin
        st_nxt.fsm = nvsc_pkg::NVSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= HOST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // bus access engine
  // ---------------------------------------------------------------
  nvsc_access u_acc (
    .clk        (clk),
    .rst_b      (rst_b),
    .start      (acc_start),
    .is_write   (st_r.cmd == nvsc_pkg::NVSC_CMD_WRITE), // R3
    .drive_oe   (1'b1),
    .dq_in_sync (st_r.dq_s2),
    .chip_sel_n (chip_sel_n),
    .write_n    (write_n),
    .out_en_n   (out_en_n),
    .dq_oe      (dq_oe),
    .done       (acc_done),
    .rd_data    (acc_rd)
  );

  // ---------------------------------------------------------------
  // pin and handshake outputs
  // ---------------------------------------------------------------
  // ready is combinational so a command is taken in the first idle cycle
  assign cmd_ready        = (st_r.fsm == nvsc_pkg::NVSC_IDLE) & st_r.busy_s[1]; // R15
  assign rsp_valid        = st_r.rsp;
  assign rsp_rdata        = st_r.rdata;
  // setting change stays flagged until a store has saved it
  assign save_changed     = st_r.chg; // R11

  // address held for the whole access; the next step's address stands through the gap
  assign mem_addr         = st_r.addr;
  // sequences enable both byte lanes; ordinary accesses use cmd_bytes
  assign upper_byte_sel_n = chip_sel_n | (seq_cmd ? 1'b0 : ~st_r.bytes[1]); // R9
  assign lower_byte_sel_n = chip_sel_n | (seq_cmd ? 1'b0 : ~st_r.bytes[0]);
  // write data stands from take until the next command is taken
  assign dq_out           = st_r.wdata;

  // busy pin is only watched; releasing it leaves the device in charge of it
  assign store_busy_n_out = 1'b1;
  assign store_busy_n_oe  = 1'b0; // host never requests hardware store
endmodule : nvsc_host

// ===== nvsc_host_checker.sv
// Purpose: port checks for nvsc_host
// Assumes: one clock domain, sequence addresses on bits 15..0
// Notes:   timing windows follow the host's access walk
`timescale 1ns/1ps
`include "nvsc_cfg.svh"
module nvsc_host_checker #(
  parameter int unsigned TSS_CYC = `NVSC_TSS_CYC
) (
  input wire logic                    clk,
  input wire logic                    rst_b,
  input wire logic                    chip_sel_n,
  input wire logic                    write_n,
  input wire logic                    out_en_n,
  input wire logic                    dq_oe,
  input wire logic                    cmd_ready,
  input wire logic                    store_busy_n_in,
  input wire logic [`NVSC_ADDR_W-1:0] mem_addr
);
  // ---------------------------------
  // bus framing and sequence checks
  // ---------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_read_framed; !out_en_n |-> !chip_sel_n && write_n; endproperty
  a_read_framed: assert property (p_read_framed) else $error("read outside select");
  property p_idle; chip_sel_n |-> out_en_n && write_n && !dq_oe; endproperty
  a_idle: assert property (p_idle) else $error("strobe without select");
  property p_wr_drive; !write_n |-> !chip_sel_n && dq_oe; endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("write without data");
  property p_seq_read;
    !chip_sel_n && mem_addr[15:0] inside {`NVSC_SEQ_0, `NVSC_SEQ_1, `NVSC_SEQ_4} |-> write_n;
  endproperty
  a_seq_read: assert property (p_seq_read) else $error("write in sequence");
  property p_prefix_read;
    $fell(chip_sel_n) && mem_addr[15:0] == `NVSC_SEQ_2 |-> !out_en_n [*6] ##1 chip_sel_n;
  endproperty
  a_prefix_read: assert property (p_prefix_read) else $error("prefix read shape");
  property p_order;
    $fell(chip_sel_n) && mem_addr[15:0] == `NVSC_SEQ_3
      |-> ##[2:12] ($fell(chip_sel_n) && mem_addr[15:0] == `NVSC_SEQ_4);
  endproperty
  a_order: assert property (p_order) else $error("sequence out of order");
  property p_quiet;
    $rose(chip_sel_n) && $past(mem_addr[15:0]) == `NVSC_SEQ_STORE |-> chip_sel_n [*8];
  endproperty
  a_quiet: assert property (p_quiet) else $error("access in processing time");
  property p_refuse; !store_busy_n_in [*3] |-> !cmd_ready; endproperty
  a_refuse: assert property (p_refuse) else $error("ready while busy");
endmodule : nvsc_host_checker
bind nvsc_host nvsc_host_checker #(.TSS_CYC(TSS_CYC)) i_nvsc_host_checker (
  .clk(clk), .rst_b(rst_b), .chip_sel_n(chip_sel_n), .write_n(write_n),
  .out_en_n(out_en_n), .dq_oe(dq_oe), .cmd_ready(cmd_ready),
  .store_busy_n_in(store_busy_n_in), .mem_addr(mem_addr));

// ===== nvsc_pkg.sv
// Purpose: types for the soft sequence controller
// Assumes: nvsc_cfg.svh supplies the numbers
// Notes:   command codes and state encodings
package nvsc_pkg;
  typedef enum logic [2:0] {
    NVSC_CMD_READ   = 3'h0,
    NVSC_CMD_WRITE  = 3'h1,
    NVSC_CMD_STORE  = 3'h2,
    NVSC_CMD_RECALL = 3'h3,
    NVSC_CMD_PFS_OFF = 3'h4,
    NVSC_CMD_PFS_ON = 3'h5
  } nvsc_cmd_t;
  typedef enum logic [2:0] {
    NVSC_IDLE = 3'b000,
    NVSC_ACC  = 3'b001,
    NVSC_GAP  = 3'b011,
    NVSC_WAIT = 3'b010,
    NVSC_BUSY = 3'b110
  } nvsc_state_t;
endpackage : nvsc_pkg

// ===== tb_nvsc_host.sv
// Purpose: self-checking bench for nvsc_host against a device model
// Assumes: processing interval shortened to 10 cycles
// Notes:   inputs change on falling clock edges
`timescale 1ns/1ps
`include "nvsc_cfg.svh"
module tb_nvsc_host;
  logic clk, rst_b, cmd_valid, cmd_ready, rsp_valid, save_changed, busy_low, pfs_en, pfs_nv;
  logic chip_sel_n, write_n, out_en_n, ubs_n, lbs_n, dq_oe, sb_in, sb_out, sb_oe, supply_low;
  logic [`NVSC_ADDR_W-1:0] cmd_addr, mem_addr;
  logic [15:0] cmd_wdata, rsp_rdata, dq_out, dq_in, q;
  logic [1:0]  cmd_bytes;
  nvsc_pkg::nvsc_cmd_t cmd_code;
  int fail_count = 0;
  int samples_checked = 0;
  nvsc_host #(.TSS_CYC(10)) i_nvsc_host (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_bytes(cmd_bytes),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .save_changed(save_changed), .mem_addr(mem_addr), .chip_sel_n(chip_sel_n),
    .write_n(write_n), .out_en_n(out_en_n), .upper_byte_sel_n(ubs_n),
    .lower_byte_sel_n(lbs_n), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in),
    .store_busy_n_in(sb_in), .store_busy_n_out(sb_out), .store_busy_n_oe(sb_oe));
  nvsc_dev_model i_nvsc_dev_model (.mem_addr(mem_addr), .chip_sel_n(chip_sel_n),
    .write_n(write_n), .out_en_n(out_en_n), .upper_byte_sel_n(ubs_n),
    .lower_byte_sel_n(lbs_n), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in),
    .busy_low(busy_low), .pfs_en(pfs_en), .pfs_nv(pfs_nv), .supply_low(supply_low));
  // open-drain busy line with pull-up
  assign sb_in = !(busy_low || (sb_oe && !sb_out));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic end_of_test;
    $display("fail_count %0d samples_checked %0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one command, bounded waits for acceptance and answer
  task automatic issue(input nvsc_pkg::nvsc_cmd_t c, input logic [17:0] a,
                       input logic [15:0] d, input logic [1:0] b);
    int n;
    cmd_code = c;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_bytes = b;
    cmd_valid = 1'b1;
    for (n = 0; n < 200 && cmd_ready !== 1'b1; n++) @(negedge clk);
    if (n == 200) begin
      $display("FAIL %0t never ready", $time);
      fail_count++;
      end_of_test();
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    for (n = 0; n < 3000 && rsp_valid !== 1'b1; n++) @(negedge clk);
    q = rsp_rdata;
    if (n == 3000) begin
      $display("FAIL %0t no answer", $time);
      fail_count++;
      end_of_test();
    end
  endtask : issue
  task automatic t_rw;
    issue(nvsc_pkg::NVSC_CMD_WRITE, 18'h00011, 16'h1234, 2'h3);
    issue(nvsc_pkg::NVSC_CMD_WRITE, 18'h00022, 16'habcd, 2'h3);
    issue(nvsc_pkg::NVSC_CMD_WRITE, 18'h00022, 16'h55ff, 2'h1);
    issue(nvsc_pkg::NVSC_CMD_READ, 18'h00011, 16'h0000, 2'h3);
    chk(q, 16'h1234);
    issue(nvsc_pkg::NVSC_CMD_READ, 18'h00022, 16'h0000, 2'h3);
    chk(q, 16'habff);
  endtask : t_rw
  task automatic t_pfs;
    chk({15'h0, pfs_en}, 16'h0001);
    // stray prefix read first: the matcher must restart on the real sequence
    issue(nvsc_pkg::NVSC_CMD_READ, 18'h04e38, 16'h0000, 2'h3);
    issue(nvsc_pkg::NVSC_CMD_PFS_OFF, 18'h0, 16'h0, 2'h3);
    chk({14'h0, pfs_en, save_changed}, 16'h0001);
    issue(nvsc_pkg::NVSC_CMD_STORE, 18'h0, 16'h0, 2'h3);
    chk({14'h0, pfs_nv, save_changed}, 16'h0000);
    issue(nvsc_pkg::NVSC_CMD_PFS_ON, 18'h0, 16'h0, 2'h3);
    chk({15'h0, pfs_en}, 16'h0001);
    issue(nvsc_pkg::NVSC_CMD_RECALL, 18'h0, 16'h0, 2'h3);
    chk({15'h0, pfs_en}, 16'h0000);
  endtask : t_pfs
  task automatic t_recall;
    issue(nvsc_pkg::NVSC_CMD_WRITE, 18'h00033, 16'ha5a5, 2'h3);
    issue(nvsc_pkg::NVSC_CMD_STORE, 18'h0, 16'h0, 2'h3);
    chk({15'h0, busy_low}, 16'h0000);
    issue(nvsc_pkg::NVSC_CMD_WRITE, 18'h00033, 16'h0f0f, 2'h3);
    issue(nvsc_pkg::NVSC_CMD_RECALL, 18'h0, 16'h0, 2'h3);
    issue(nvsc_pkg::NVSC_CMD_READ, 18'h00033, 16'h0000, 2'h3);
    chk(q, 16'ha5a5);
    // a write while supply is low must leave the word untouched
    supply_low = 1'b1;
    issue(nvsc_pkg::NVSC_CMD_WRITE, 18'h00033, 16'h1111, 2'h3);
    supply_low = 1'b0;
    issue(nvsc_pkg::NVSC_CMD_READ, 18'h00033, 16'h0000, 2'h3);
    chk(q, 16'ha5a5);
    chk({14'h0, sb_oe, sb_out}, 16'h0001);
  endtask : t_recall
  // main sequence: reset, then scenarios back to back
  initial begin
    rst_b = 1'b0;
    cmd_valid = 1'b0;
    cmd_code = nvsc_pkg::NVSC_CMD_READ;
    cmd_addr = '0;
    cmd_wdata = 16'h0000;
    cmd_bytes = 2'h0;
    supply_low = 1'b0;
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    t_rw();
    t_pfs();
    t_recall();
    end_of_test();
  end
endmodule : tb_nvsc_host
